// *** src/lpc_pkg.sv ***
// Package for the LCD/PWM clock and shared-pin mode controller.
// Assumes the command front end delivers whole command bytes with a one-cycle strobe.
package lpc_pkg;
	// Command byte opcodes and masks.
	localparam logic [4:0] OSC_CMD_TAG     = 5'h03;
	localparam logic [2:0] FRAME_CMD_TAG   = 3'h1;
	localparam logic [3:0] PM_CMD_PAIR01   = 4'hc;
	localparam logic [3:0] PM_CMD_PAIR23   = 4'hd;
	localparam logic [3:0] PM_CMD_PAIR45   = 4'he;
	// Field positions in the oscillator-control byte.
	localparam int         OSC_SRC_BIT     = 0;
	localparam int         OSC_COE_BIT     = 1;
	localparam int         OSC_EFR_BIT     = 2;
	// Pin mode encodings.
	localparam logic [1:0] PM_LCD0         = 2'h0;
	localparam logic [1:0] PM_LCD1         = 2'h1;
	localparam logic [1:0] PM_STATIC       = 2'h2;
	localparam logic [1:0] PM_PWM          = 2'h3;
	// Reset values.
	localparam logic [2:0] OSC_CTRL_RESET  = 3'h0;
	localparam logic [1:0] PM_RESET        = 2'h0;
	localparam logic [4:0] FRAME_DIV_RESET = 5'h0e;
	// Timing: the frame is 48 pin clocks (9.6 kHz) or 48*q oscillator clocks.
	localparam int         FRAME_BASE_DIV  = 48;
	localparam int         NUM_SHARED      = 6;
	// Divide factor q per frame divider code; codes 18 and above clamp to 20.
	function automatic logic [6:0] lpc_q_of(input logic [4:0] fd);
		case (fd)
			5'h00: lpc_q_of = 7'h50;
			5'h01: lpc_q_of = 7'h44;
			5'h02: lpc_q_of = 7'h3c;
			5'h03: lpc_q_of = 7'h35;
			5'h04: lpc_q_of = 7'h30;
			5'h05: lpc_q_of = 7'h2c;
			5'h06: lpc_q_of = 7'h28;
			5'h07: lpc_q_of = 7'h25;
			5'h08: lpc_q_of = 7'h22;
			5'h09: lpc_q_of = 7'h20;
			5'h0a: lpc_q_of = 7'h1e;
			5'h0b: lpc_q_of = 7'h1c;
			5'h0c: lpc_q_of = 7'h1b;
			5'h0d: lpc_q_of = 7'h19;
			5'h0e: lpc_q_of = 7'h18;
			5'h0f: lpc_q_of = 7'h17;
			5'h10: lpc_q_of = 7'h16;
			5'h11: lpc_q_of = 7'h15;
			default: lpc_q_of = 7'h14;
		endcase
	endfunction
endpackage

// *** src/lpc_sync.sv ***
// Three-stage synchroniser with agreement filter for one asynchronous pin.
// Assumes clk is the block clock; output changes once stages two and three agree.
`timescale 1ns/1ps
module lpc_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Pin and filtered level
	input  wire logic din,
	output logic      dout
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic out_q;
	wire  agree = (s2_q == s3_q);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			out_q <= 1'b0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (agree) begin
				out_q <= s3_q;
			end
		end
	end

	assign dout = out_q;
endmodule

// *** src/lpc_ctrl.sv ***
// Clock-source selection, oscillator enable, clock pin direction, frame timing
// and shared-pin mode selection for an LCD driver with PWM generator.
// Assumes the serial front end hands over command bytes with a one-cycle strobe,
// the oscillator is a separate macro gated by osc_en, and osc_tick is a
// synchronous one-cycle pulse per oscillator period (230 kHz nominal).
`timescale 1ns/1ps
module lpc_ctrl
	import lpc_pkg::*;
#(
	parameter int N_PINS = 6
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// Command bytes from the serial front end
	input  wire logic              cmd_valid,
	input  wire logic [7:0]        cmd_byte,
	// Loose configuration bits held elsewhere
	input  wire logic              power_down_bit,
	input  wire logic              pwm_enable,
	input  wire logic [N_PINS-1:0] static_level_bits,
	// Oscillator macro
	input  wire logic              osc_tick,
	output logic                   osc_en,
	// Clock pin, three signals
	input  wire logic              clock_pin_i,
	output logic                   clock_pin_o,
	output logic                   clock_pin_oe,
	// Clock ticks to the LCD and PWM engines
	output logic                   lcd_clk_tick,
	output logic                   pwm_clk_tick,
	output logic                   frame_tick,
	// Shared pin drive
	input  wire logic [N_PINS-1:0] segment_drive,
	input  wire logic [N_PINS-1:0] pwm_drive,
	output logic [N_PINS-1:0]      shared_pin,
	// Status
	output logic [2:0]             osc_ctrl_state,
	output logic [4:0]             frame_divider_field
);
	import lpc_pkg::*;

	// The pair decode and the mode table are built for six pins only.
	if (N_PINS != NUM_SHARED) begin : g_bad_pins
		$error("lpc_ctrl supports exactly six shared pins");
	end

	// Oscillator-control, frame and pin mode registers.
	logic [2:0] osc_ctrl_q;
	logic [4:0] fd_q;
	logic [1:0] mode_q [N_PINS];

	wire clock_source_select = osc_ctrl_q[OSC_SRC_BIT];
	wire clock_out_enable    = osc_ctrl_q[OSC_COE_BIT];
	wire external_freq_range = osc_ctrl_q[OSC_EFR_BIT];

	wire osc_cmd   = cmd_valid && (cmd_byte[7:3] == OSC_CMD_TAG);
	wire frame_cmd = cmd_valid && (cmd_byte[7:5] == FRAME_CMD_TAG);
	wire pm_cmd0   = cmd_valid && (cmd_byte[7:4] == PM_CMD_PAIR01);
	wire pm_cmd1   = cmd_valid && (cmd_byte[7:4] == PM_CMD_PAIR23);
	wire pm_cmd2   = cmd_valid && (cmd_byte[7:4] == PM_CMD_PAIR45);
	wire [2:0] pm_sel = {pm_cmd2, pm_cmd1, pm_cmd0};

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			osc_ctrl_q <= OSC_CTRL_RESET;
			fd_q       <= FRAME_DIV_RESET;
		end else begin
			if (osc_cmd) begin
				osc_ctrl_q <= cmd_byte[2:0];
			end
			if (frame_cmd) begin
				fd_q <= cmd_byte[4:0];
			end
		end
	end

	// Each pair register: odd pin from bits 3:2, even pin from bits 1:0.
	genvar gp;
	generate
		for (gp = 0; gp < N_PINS; gp++) begin : g_mode
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					mode_q[gp] <= PM_RESET;
				end else if (pm_sel[gp/2]) begin
					mode_q[gp] <= (gp % 2 == 1) ? cmd_byte[3:2] : cmd_byte[1:0];
				end
			end
		end
	endgenerate

	// Oscillator enable. Async reset forces the register low, so reset stops it.
	wire ext_low  = clock_source_select && !external_freq_range;
	wire osc_need = !power_down_bit &&
	                (!clock_source_select || (pwm_enable && ext_low));
	logic osc_en_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			osc_en_q <= 1'b0;
		end else begin
			osc_en_q <= osc_need;
		end
	end

	// External clock pin passes the synchroniser; rising edges become ticks.
	logic pin_sync;
	logic pin_prev_q;
	lpc_sync u_sync (
		.clk  (clk),
		.rstn (rstn),
		.din  (clock_pin_i),
		.dout (pin_sync)
	);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= pin_sync;
		end
	end
	wire pin_tick  = pin_sync && !pin_prev_q;
	wire osc_valid = osc_tick && osc_en_q;

	// Source of the 230 kHz-class clock used for the prescaler.
	wire main_tick = clock_source_select ? pin_tick : osc_valid;
	// PWM needs 230 kHz: a slow external clock hands PWM to the oscillator.
	wire pwm_tick_d = ext_low ? osc_valid : main_tick;

	// Prescaler by q: its carry is the intermediate clock at 230k/q. With a slow
	// external clock the prescaler is bypassed, so the pin clock is already it.
	wire [6:0] q_val = lpc_q_of(fd_q);
	logic [6:0] pre_cnt_q;
	wire        pre_wrap  = (pre_cnt_q >= q_val - 7'h1);
	wire        inter_tick = ext_low ? pin_tick : (main_tick && pre_wrap);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pre_cnt_q <= 7'h0;
		end else if (main_tick && !ext_low) begin
			pre_cnt_q <= pre_wrap ? 7'h0 : pre_cnt_q + 7'h1;
		end
	end

	// Frame counter: 48 intermediate ticks per LCD frame.
	localparam logic [5:0] FRAME_LAST = 6'(FRAME_BASE_DIV - 1);
	logic [5:0] frm_cnt_q;
	wire        frm_wrap = (frm_cnt_q == FRAME_LAST);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			frm_cnt_q <= 6'h0;
		end else if (inter_tick) begin
			frm_cnt_q <= frm_wrap ? 6'h0 : frm_cnt_q + 6'h1;
		end
	end

	// Pin clock: high for the first q/2 (rounded down) prescaler counts, so its duty
	// is an exact half for even q and falls just below half for odd q.
	wire [6:0] half_q   = q_val >> 1;
	wire       pin_clk  = (pre_cnt_q < half_q);
	wire       drive_ck = !clock_source_select && clock_out_enable;
	wire       pd_hold  = power_down_bit && clock_out_enable;
	wire       oe_d     = drive_ck || pd_hold;
	// In power-down with clock out on, the pin sits high instead of toggling.
	wire       o_d      = power_down_bit ? 1'b1 : pin_clk;

	// Shared pin selection per mode.
	logic [N_PINS-1:0] pin_d;
	generate
		for (gp = 0; gp < N_PINS; gp++) begin : g_pin
			wire is_pwm = (mode_q[gp] == PM_PWM);
			wire is_st  = (mode_q[gp] == PM_STATIC);
			assign pin_d[gp] = is_pwm ? (power_down_bit ? static_level_bits[gp]
			                                            : pwm_drive[gp])
			                 : is_st  ? static_level_bits[gp]
			                          : segment_drive[gp];
		end
	endgenerate

	// Output registers. Reset leaves the pin undriven and all ticks low.
	logic              ck_o_q;
	logic              ck_oe_q;
	logic              lcd_q;
	logic              pwm_q;
	logic              frm_q;
	logic [N_PINS-1:0] shared_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ck_o_q   <= 1'b0;
			ck_oe_q  <= 1'b0;
			lcd_q    <= 1'b0;
			pwm_q    <= 1'b0;
			frm_q    <= 1'b0;
			shared_q <= '0;
		end else begin
			ck_o_q   <= o_d;
			ck_oe_q  <= oe_d;
			lcd_q    <= inter_tick;
			pwm_q    <= pwm_tick_d;
			frm_q    <= inter_tick && frm_wrap;
			shared_q <= pin_d;
		end
	end

	assign osc_en              = osc_en_q;
	assign clock_pin_o         = ck_o_q;
	assign clock_pin_oe        = ck_oe_q;
	assign lcd_clk_tick        = lcd_q;
	assign pwm_clk_tick        = pwm_q;
	assign frame_tick          = frm_q;
	assign shared_pin          = shared_q;
	assign osc_ctrl_state      = osc_ctrl_q;
	assign frame_divider_field = fd_q;
endmodule

// *** sim/lpc_ctrl_sva.sv ***
// Concurrent checks on the clock and pin mode controller ports.
// Assumes binding into lpc_ctrl; all checks run on clk and stop in reset.
`timescale 1ns/1ps
module lpc_ctrl_sva
	import lpc_pkg::*;
#(
	parameter int N_PINS = 6
) (
	// Clock, reset, commands and the other controller inputs
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic              cmd_valid,
	input wire logic [7:0]        cmd_byte,
	input wire logic              power_down_bit,
	input wire logic              pwm_enable,
	input wire logic [N_PINS-1:0] static_level_bits,
	input wire logic [N_PINS-1:0] segment_drive,
	input wire logic [N_PINS-1:0] pwm_drive,
	// Observed outputs
	input wire logic              osc_en,
	input wire logic              clock_pin_o,
	input wire logic              clock_pin_oe,
	input wire logic              lcd_clk_tick,
	input wire logic [N_PINS-1:0] shared_pin,
	input wire logic [2:0]        osc_ctrl_state,
	input wire logic [4:0]        frame_divider_field
);
	logic [7:0]        byte_q;
	logic [1:0]        up_q;
	logic [1:0]        mode_q [N_PINS];
	logic [N_PINS-1:0] exp_pin;
	wire logic up = (up_q == 2'h3);
	wire logic osc_hit = cmd_valid && cmd_byte[7:3] == OSC_CMD_TAG;
	wire logic frm_hit = cmd_valid && cmd_byte[7:5] == FRAME_CMD_TAG;
	wire logic pm_hit = cmd_valid && cmd_byte[7:6] == 2'h3 && cmd_byte[5:4] != 2'h3;
	wire logic en_exp = !power_down_bit && (!osc_ctrl_state[0]
		|| (pwm_enable && !osc_ctrl_state[2]));
	wire logic oe_exp = osc_ctrl_state[1] && (!osc_ctrl_state[0] || power_down_bit);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			byte_q <= 8'h00;
			up_q <= 2'h0;
			for (int k = 0; k < N_PINS; k++) mode_q[k] <= PM_RESET;
		end else begin
			byte_q <= cmd_byte;
			if (!up) up_q <= up_q + 2'h1;
			if (pm_hit) begin
				mode_q[{cmd_byte[5:4], 1'b0}] <= cmd_byte[1:0];
				mode_q[{cmd_byte[5:4], 1'b1}] <= cmd_byte[3:2];
			end
		end
	end
	// Power-down replaces PWM drive on the pin, so it is folded into the mode decode.
	always_comb begin
		for (int k = 0; k < N_PINS; k++) begin
			exp_pin[k] = segment_drive[k];
			if (mode_q[k] == PM_STATIC || (mode_q[k] == PM_PWM && power_down_bit))
				exp_pin[k] = static_level_bits[k];
			else if (mode_q[k] == PM_PWM)
				exp_pin[k] = pwm_drive[k];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_pd_held;
		power_down_bit ##1 power_down_bit;
	endsequence
	a_osc_cmd_load: assert property (osc_hit |=> osc_ctrl_state == byte_q[2:0])
		else $error("oscillator byte not loaded");
	a_frame_cmd_load: assert property (frm_hit |=> frame_divider_field == byte_q[4:0])
		else $error("frame divider byte not loaded");
	a_other_ignored: assert property (
		cmd_valid && !osc_hit && !frm_hit && !pm_hit
		|=> $stable(osc_ctrl_state) && $stable(frame_divider_field))
		else $error("foreign byte changed the configuration");
	a_osc_enable: assert property (up |-> osc_en == $past(en_exp))
		else $error("oscillator enable wrong");
	a_pin_drive: assert property (up |-> clock_pin_oe == $past(oe_exp))
		else $error("clock pin direction wrong");
	a_pd_pin_high: assert property (
		up && $past(power_down_bit && osc_ctrl_state[1]) |-> clock_pin_o)
		else $error("clock pin not high in power-down");
	a_shared_mode: assert property (up |-> shared_pin == $past(exp_pin))
		else $error("shared pin drive wrong");
	a_pd_osc_off: assert property (s_pd_held |-> !osc_en)
		else $error("oscillator runs in power-down");
	a_tick_single: assert property (lcd_clk_tick |=> !lcd_clk_tick)
		else $error("intermediate tick longer than one cycle");
endmodule

// *** sim/lpc_host.sv ***
// Host model: sends command bytes and plays the far party on the clock pin.
// Assumes falling-edge driving; the pin has no pull, so undriven it toggles.
`timescale 1ns/1ps
module lpc_host (
	// Clock
	input  wire logic  clk,
	// Command port
	output logic       cmd_valid,
	output logic [7:0] cmd_byte,
	// Clock pin
	input  wire logic  clock_pin_o,
	input  wire logic  clock_pin_oe,
	input  wire logic  ext_run,
	output logic       clock_pin_i
);
	logic ext_lvl = 1'b0;
	int   ph = 0;
	initial begin
		cmd_valid = 1'b0;
		cmd_byte = 8'h00;
	end
	assign clock_pin_i = clock_pin_oe ? clock_pin_o : ext_lvl;
	// Running clock has a 20-cycle period; kept up while the display needs it.
	always @(negedge clk) begin
		ph <= (ph == 9) ? 0 : ph + 1;
		if (!ext_run || ph == 9) ext_lvl <= ~ext_lvl;
	end
	task automatic send(input logic [7:0] b);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_byte = b;
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask
endmodule

// *** sim/tb_lpc_ctrl.sv ***
// Bench for the clock and pin mode controller: command sequences and timing counts.
// Assumes the oscillator is modelled as one tick every two cycles while enabled.
`timescale 1ns/1ps
module tb_lpc_ctrl;
	import lpc_pkg::*;
	localparam int N_PINS = NUM_SHARED;
	logic       clk = 0, rstn = 0, pd = 0, pwm = 0, osc_tick = 0, ext_run = 0;
	logic       cmd_valid, pin_i, pin_o, pin_oe, lcd_t, pwm_t, frm_t, osc_en;
	logic [7:0] cmd_byte;
	logic [5:0] stat = 6'h0f, seg = 6'h15, pwmd = 6'h33, spin;
	logic [2:0] ocs;
	logic [4:0] fdf;
	int         n_mismatch = 0, check_count = 0, cyc = 0;
	lpc_host host_u (.clk(clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
		.clock_pin_o(pin_o), .clock_pin_oe(pin_oe), .ext_run(ext_run), .clock_pin_i(pin_i));
	lpc_ctrl #(.N_PINS(N_PINS)) dut_u (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte), .power_down_bit(pd), .pwm_enable(pwm), .static_level_bits(stat),
		.osc_tick(osc_tick), .osc_en(osc_en), .clock_pin_i(pin_i), .clock_pin_o(pin_o),
		.clock_pin_oe(pin_oe), .lcd_clk_tick(lcd_t), .pwm_clk_tick(pwm_t), .frame_tick(frm_t),
		.segment_drive(seg), .pwm_drive(pwmd), .shared_pin(spin), .osc_ctrl_state(ocs),
		.frame_divider_field(fdf));
	always #25 clk = ~clk;
	always @(negedge clk) osc_tick <= osc_en & ~osc_tick;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cfg(input logic [7:0] b);
		host_u.send(b);
		repeat (3) @(negedge clk);
	endtask
	function automatic logic pick(input int s);
		return s == 0 ? lcd_t : s == 1 ? pwm_t : s == 2 ? frm_t : pin_o;
	endfunction
	function automatic logic pin_of(input logic [1:0] m, input int k);
		if (m == PM_STATIC || (m == PM_PWM && pd)) return stat[k];
		return m == PM_PWM ? pwmd[k] : seg[k];
	endfunction
	// Pulses are timed edge to edge; selector 3 times the high phase of the pin clock.
	task automatic gap(input int s, input int exp);
		int n;
		n = 0;
		while (pick(s) !== 1'b0 && n < 6000) begin @(negedge clk); n++; end
		n = 0;
		while (pick(s) !== 1'b1 && n < 6000) begin @(negedge clk); n++; end
		n = 0;
		do begin @(negedge clk); n++; end while (pick(s) !== (s != 3) && n < 6000);
		check(n, exp);
	endtask
	initial begin
		logic [2:0] c;
		logic [1:0] m;
		logic [5:0] e;
		repeat (16) @(negedge clk);
		rstn = 1;
		@(negedge clk);
		check(ocs, OSC_CTRL_RESET);
		check(fdf, FRAME_DIV_RESET);
		check(pin_oe, 1'b0);
		check(spin, seg);
		$display("reset test done");
		for (int i = 0; i < 32; i++) begin
			pd = i[4];
			pwm = i[3];
			c = i[2:0];
			cfg({OSC_CMD_TAG, c});
			check(ocs, c);
			check(osc_en, !pd && (!c[0] || (pwm && !c[2])));
			check(pin_oe, c[1] && (!c[0] || pd));
			if (pd && c[1]) check(pin_o, 1'b1);
		end
		cfg(8'h05);
		check(ocs, 3'h7);
		$display("oscillator test done");
		// Static and segment levels flip so every pin can tell all three modes apart.
		for (int i = 0; i < 32; i++) begin
			pd = i[2];
			m = i[1:0];
			stat = i[3] ? 6'h30 : 6'h0f;
			seg = i[4] ? 6'h2a : 6'h15;
			for (int p = 0; p < 3; p++) cfg({PM_CMD_PAIR01 + 4'(p), m, ~m});
			for (int k = 0; k < 6; k++) e[k] = pin_of(k[0] ? m : ~m, k);
			check(spin, e);
		end
		cfg(8'hf0);
		check(spin, e);
		$display("pin mode test done");
		pd = 0;
		pwm = 1;
		cfg(8'h1a);
		gap(0, 48);
		gap(3, 24);
		gap(2, 2304);
		gap(1, 2);
		cfg(8'h32);
		check(fdf, 5'h12);
		gap(2, 1920);
		cfg(8'h3f);
		gap(0, 40);
		$display("internal clock test done");
		rstn = 0;
		@(negedge clk);
		check(osc_en, 1'b0);
		check(pin_oe, 1'b0);
		rstn = 1;
		@(negedge clk);
		check(ocs, OSC_CTRL_RESET);
		check(fdf, FRAME_DIV_RESET);
		check(pin_oe, 1'b0);
		check(osc_en, 1'b1);
		cfg(8'h3f);
		check(fdf, 5'h1f);
		$display("mid-run reset test done");
		ext_run = 1;
		cfg(8'h19);
		gap(0, 20);
		gap(2, 960);
		gap(1, 2);
		cfg(8'h1d);
		check(osc_en, 1'b0);
		gap(1, 20);
		gap(0, 400);
		$display("external clock test done");
		report_and_stop();
	end
endmodule
bind lpc_ctrl lpc_ctrl_sva #(.N_PINS(N_PINS)) chk_u (.clk, .rstn, .cmd_valid, .cmd_byte,
	.power_down_bit, .pwm_enable, .static_level_bits, .segment_drive, .pwm_drive, .osc_en,
	.clock_pin_o, .clock_pin_oe, .lcd_clk_tick, .shared_pin, .osc_ctrl_state,
	.frame_divider_field);
